// [design/rtcf_cfg.svh]
`ifndef RTCF_CFG_SVH
`define RTCF_CFG_SVH
// Function
// - countdown flag set per period, software clears
// - countdown irq pulse or level, gated enable
// - countdown read returns live counter
// - minsec and alarm flags sticky until written
// - flag write ANDs value into flags
// - control-2 bit layout fixed
// - single active-low interrupt output
// - correction pulse lasts 1/128 second
// - alarm irq follows alarm flag level
// - sources wired-OR onto one output
// - minsec pulse from 128 Hz, 1/64 s
// - clearing minsec flag ends pulse
// - level mode minsec removed by enables/flag
// - countdown pulse width per source and reload
// - clearing countdown flag ends pulse
// - level mode timer interrupt enable clear removes irq
// - correction cut bit ends correction pulse
// - reload zero halts countdown
// - at one: flag, reload, continue
// - source select 4096/64/1/minute
`define RTCF_ADDR_CTRL2 8'h01
`define RTCF_ADDR_TMRCTL 8'h0E
`define RTCF_ADDR_COUNT 8'h0F
`define RTCF_ADDR_CTRL1 8'h00
`define RTCF_B_MI 7
`define RTCF_B_SI 6
`define RTCF_B_MSF 5
`define RTCF_B_TP 4
`define RTCF_B_AF 3
`define RTCF_B_TF 2
`define RTCF_B_AIE 1
`define RTCF_B_TIE 0
`define RTCF_B_TE 3
`define RTCF_B_CUT 5
`define RTCF_F_SRC 1:0
`define RTCF_CTRL2_RST 8'h00
`define RTCF_TMRCTL_RST 8'h73
`define RTCF_TMRCTL_MASK 8'h7B
`define RTCF_SRC_4K 2'h0
`define RTCF_SRC_64 2'h1
`define RTCF_SRC_1HZ 2'h2
`define RTCF_SRC_MIN 2'h3
`define RTCF_W64 9'h002
`define RTCF_W128 9'h001
`define RTCF_W4K_HALF 9'h001
`define RTCF_W4K 9'h001
`define RTCF_CNT_ZERO 8'h00
`define RTCF_CNT_ONE 8'h01
`endif

// [design/rtcf_pkg.sv]
package rtcf_pkg;
  typedef struct packed {
    logic tick_4k;
    logic tick_8k;
    logic tick_64;
    logic tick_128;
    logic tick_1hz;
    logic tick_min;
  } rtcf_ticks_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtcf_bus_t;
  typedef enum logic [1:0] {
    RTCF_IDLE,
    RTCF_HI,
    RTCF_LO
  } rtcf_pstate_t;
endpackage : rtcf_pkg

// [design/rtcf_irq.sv]
`timescale 1ns/100ps
`include "rtcf_cfg.svh"
module rtcf_irq import rtcf_pkg::*; (
  input wire logic clock,
  input wire logic srst,
  input wire rtcf_bus_t bus,
  input wire rtcf_ticks_t ticks,
  input wire logic minsec_event,
  input wire logic alarm_event,
  input wire logic corr_event,
  input wire logic corr_active,
  output logic [7:0] rdata,
  output logic irq_n
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic wr_to(input rtcf_bus_t b, input logic [7:0] a);
    wr_to = b.wr && (b.addr == a);
  endfunction : wr_to

  function automatic logic src_tick(input rtcf_ticks_t t, input logic [1:0] s);
    case (s)
      `RTCF_SRC_4K: src_tick = t.tick_4k;
      `RTCF_SRC_64: src_tick = t.tick_64;
      `RTCF_SRC_1HZ: src_tick = t.tick_1hz;
      default: src_tick = t.tick_min;
    endcase
  endfunction : src_tick

  logic [7:0] ctrl2_reg, ctrl2_next;
  logic [7:0] tmrctl_reg, tmrctl_next;
  logic [7:0] reload_reg, reload_next;
  logic [7:0] count_reg, count_next;
  logic expire;
  logic wr2, wrt, wrc, wr1;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    wr2 = wr_to(bus, `RTCF_ADDR_CTRL2);
    wrt = wr_to(bus, `RTCF_ADDR_TMRCTL);
    wrc = wr_to(bus, `RTCF_ADDR_COUNT);
    wr1 = wr_to(bus, `RTCF_ADDR_CTRL1);
    tmrctl_next = wrt ? (bus.wdata & `RTCF_TMRCTL_MASK) : tmrctl_reg;
    reload_next = wrc ? bus.wdata : reload_reg;
    count_next = count_reg;
    expire = 1'b0;
    if (wrc) begin
      count_next = bus.wdata;
    end else if (tmrctl_reg[`RTCF_B_TE] && reload_reg != `RTCF_CNT_ZERO &&
        src_tick(ticks, tmrctl_reg[`RTCF_F_SRC])) begin
      if (count_reg <= `RTCF_CNT_ONE) begin
        expire = 1'b1;
        count_next = reload_reg;
      end else begin
        count_next = count_reg - 8'h01;
      end
    end
    ctrl2_next = ctrl2_reg;
    if (wr2) begin
      ctrl2_next = bus.wdata;
      // flags take the AND of old and written values
      ctrl2_next[`RTCF_B_MSF] = ctrl2_reg[`RTCF_B_MSF] & bus.wdata[`RTCF_B_MSF];
      ctrl2_next[`RTCF_B_AF] = ctrl2_reg[`RTCF_B_AF] & bus.wdata[`RTCF_B_AF];
      ctrl2_next[`RTCF_B_TF] = ctrl2_reg[`RTCF_B_TF] & bus.wdata[`RTCF_B_TF];
    end
    // set wins over a clearing write in the same cycle
    if (minsec_event) ctrl2_next[`RTCF_B_MSF] = 1'b1;
    if (alarm_event) ctrl2_next[`RTCF_B_AF] = 1'b1;
    if (expire) ctrl2_next[`RTCF_B_TF] = 1'b1;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl2_reg <= `RTCF_CTRL2_RST;
      tmrctl_reg <= `RTCF_TMRCTL_RST;
      reload_reg <= `RTCF_CNT_ZERO;
      count_reg <= `RTCF_CNT_ZERO;
    end else begin
      ctrl2_reg <= ctrl2_next;
      tmrctl_reg <= tmrctl_next;
      reload_reg <= reload_next;
      count_reg <= count_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pulse widths counted in 128 Hz ticks; 4 kHz widths in 8 kHz ticks
  logic [8:0] ms_cnt_reg, ms_cnt_next;
  logic [8:0] tf_cnt_reg, tf_cnt_next;
  logic [8:0] co_cnt_reg, co_cnt_next;
  logic tf_fast_reg, tf_fast_next;
  logic minsec_en, ms_on, tf_on, co_on, al_on;
  logic tf_step;
  logic irq_n_next;
  logic [7:0] rdata_next;

  always_comb begin
    minsec_en = ctrl2_reg[`RTCF_B_MI] | ctrl2_reg[`RTCF_B_SI];
    ms_cnt_next = ms_cnt_reg;
    if (minsec_event && minsec_en) begin
      ms_cnt_next = `RTCF_W64;
    end else if (!ctrl2_next[`RTCF_B_MSF]) begin
      ms_cnt_next = 9'h000;
    end else if (ms_cnt_reg != 9'h000 && ticks.tick_128) begin
      ms_cnt_next = ms_cnt_reg - 9'h001;
    end
    tf_fast_next = tf_fast_reg;
    tf_cnt_next = tf_cnt_reg;
    tf_step = tf_fast_reg ? ticks.tick_8k : ticks.tick_128;
    if (expire) begin
      case (tmrctl_reg[`RTCF_F_SRC])
        `RTCF_SRC_4K: begin
          tf_fast_next = 1'b1;
          tf_cnt_next = (reload_reg == `RTCF_CNT_ONE) ? `RTCF_W4K_HALF : `RTCF_W4K + 9'h001;
        end
        `RTCF_SRC_64: begin
          tf_fast_next = 1'b0;
          tf_cnt_next = (reload_reg == `RTCF_CNT_ONE) ? `RTCF_W128 : `RTCF_W64;
        end
        default: begin
          tf_fast_next = 1'b0;
          tf_cnt_next = `RTCF_W64;
        end
      endcase
    end else if (!ctrl2_next[`RTCF_B_TF]) begin
      tf_cnt_next = 9'h000;
    end else if (tf_cnt_reg != 9'h000 && tf_step) begin
      tf_cnt_next = tf_cnt_reg - 9'h001;
    end
    co_cnt_next = co_cnt_reg;
    if (corr_event) begin
      co_cnt_next = `RTCF_W128;
    end else if (wr1 && bus.wdata[`RTCF_B_CUT]) begin
      co_cnt_next = 9'h000;
    end else if (co_cnt_reg != 9'h000 && ticks.tick_128) begin
      co_cnt_next = co_cnt_reg - 9'h001;
    end
    if (ctrl2_next[`RTCF_B_TP]) begin
      ms_on = ms_cnt_next != 9'h000;
      tf_on = ctrl2_next[`RTCF_B_TIE] && tf_cnt_next != 9'h000;
    end else begin
      ms_on = minsec_en && ctrl2_next[`RTCF_B_MSF];
      tf_on = ctrl2_next[`RTCF_B_TIE] && ctrl2_next[`RTCF_B_TF];
    end
    al_on = ctrl2_next[`RTCF_B_AIE] && ctrl2_next[`RTCF_B_AF];
    co_on = (co_cnt_next != 9'h000) && corr_active;
    irq_n_next = ~(ms_on | tf_on | al_on | co_on);
    rdata_next = rdata;
    if (bus.rd) begin
      case (bus.addr)
        `RTCF_ADDR_CTRL2: rdata_next = ctrl2_reg;
        `RTCF_ADDR_TMRCTL: rdata_next = tmrctl_reg;
        `RTCF_ADDR_COUNT: rdata_next = count_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ms_cnt_reg <= 9'h000;
      tf_cnt_reg <= 9'h000;
      co_cnt_reg <= 9'h000;
      tf_fast_reg <= 1'b0;
      irq_n <= 1'b1;
      rdata <= 8'h00;
    end else begin
      ms_cnt_reg <= ms_cnt_next;
      tf_cnt_reg <= tf_cnt_next;
      co_cnt_reg <= co_cnt_next;
      tf_fast_reg <= tf_fast_next;
      irq_n <= irq_n_next;
      rdata <= rdata_next;
    end
  end

endmodule : rtcf_irq

// [verification/rtcf_irq_chk.sv]
`timescale 1ns/100ps
module rtcf_irq_chk import rtcf_pkg::*; (
  input wire logic clock,
  input wire logic srst,
  input wire rtcf_bus_t bus,
  input wire rtcf_ticks_t ticks,
  input wire logic minsec_event,
  input wire logic alarm_event,
  input wire logic corr_event,
  input wire logic corr_active,
  input wire logic [7:0] rdata,
  input wire logic irq_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // shadow of control-2 so a release can be tied to the only live source
  logic [7:0] sh;
  wire w2 = bus.wr && bus.addr == 8'h01;
  wire [7:0] m = w2 ? bus.wdata : 8'hFF;
  wire [7:0] c = w2 ? bus.wdata : sh;
  wire q = !minsec_event && !alarm_event && !corr_event;
  always_ff @(posedge clock) begin
    if (srst) begin
      sh <= 8'h00;
    end else begin
      sh <= {c[7:6], sh[5] & m[5] | minsec_event, c[4], sh[3] & m[3] | alarm_event, 1'b0,
        c[1:0]};
    end
  end
  rst_irq_a: assert property (disable iff (1'b0) srst |=> irq_n)
    else $error("interrupt active after reset");
  unmap_rd_a: assert property (bus.rd && bus.addr inside {[8'h02:8'h0D], [8'h10:8'hFF]}
    |=> rdata == 8'h00) else $error("unmapped read not zero");
  rd_hold_a: assert property (!bus.rd |=> $stable(rdata))
    else $error("read data moved without a read");
  alarm_on_a: assert property (alarm_event && sh[1] |-> ##[1:2] !irq_n)
    else $error("alarm did not raise interrupt");
  alarm_off_a: assert property (w2 && bus.wdata == 8'h02 && sh == 8'h0A && q
    |-> ##[1:2] irq_n) else $error("alarm clear did not release");
  ms_on_a: assert property (minsec_event && (sh[7] | sh[6]) |-> ##[1:2] !irq_n)
    else $error("minute event did not raise interrupt");
  ms_cut_a: assert property (w2 && bus.wdata == 8'h90 && sh == 8'hB0 && q
    |-> ##[1:2] irq_n) else $error("minute pulse not cut");
  corr_on_a: assert property (corr_event && corr_active |-> ##[1:2] !irq_n)
    else $error("correction pulse missing");
endmodule : rtcf_irq_chk
bind rtcf_irq rtcf_irq_chk chk (.clock(clock), .srst(srst), .bus(bus), .ticks(ticks),
  .minsec_event(minsec_event), .alarm_event(alarm_event), .corr_event(corr_event),
  .corr_active(corr_active), .rdata(rdata), .irq_n(irq_n));

// [verification/rtcf_host.sv]
`timescale 1ns/100ps
module rtcf_host import rtcf_pkg::*; (
  input wire logic clock,
  input wire logic [7:0] rdata,
  output rtcf_bus_t bus
);
  initial bus = '{1'b0, 1'b0, 8'h00, 8'h00};
  // two cycles a transfer, half the period of the fastest timer source (4 kHz)
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] r);
    bus <= '{w, !w, a, d};
    @(posedge clock);
    bus <= '{1'b0, 1'b0, ~a, ~d};
    @(posedge clock);
    r = rdata;
  endtask : xfer
endmodule : rtcf_host

// [verification/rtcf_irq_tb.sv]
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module rtcf_irq_tb import rtcf_pkg::*; ;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [2:0] ev = 3'h0;
  logic ca = 1'b0;
  logic [7:0] tc = 8'h00;
  logic [7:0] v;
  logic [7:0] rdata;
  logic irq_n;
  rtcf_ticks_t ticks = '0;
  rtcf_bus_t bus;
  int n_fail = 0;
  int samples_checked = 0;
  always #10 clock = ~clock;
  always @(posedge clock) begin
    tc <= tc + 8'h01;
    ticks <= {tc[1:0] == 2'h3, tc[0], tc[4:0] == 5'h1F, tc[3:0] == 4'hF, tc[5:0] == 6'h3F,
      tc == 8'hFF};
  end
  rtcf_host h (.clock(clock), .rdata(rdata), .bus(bus));
  rtcf_irq DUT (.clock(clock), .srst(srst), .bus(bus), .ticks(ticks), .minsec_event(ev[2]),
    .alarm_event(ev[1]), .corr_event(ev[0]), .corr_active(ca), .rdata(rdata), .irq_n(irq_n));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    h.xfer(1'b1, a, d, v);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    h.xfer(1'b0, a, 8'h00, v);
    `CHK(v, e)
  endtask : rd
  task automatic pulse(input logic [2:0] e);
    ev <= e;
    @(posedge clock);
    ev <= 3'h0;
    @(posedge clock);
  endtask : pulse
  // sampled at the falling edge so the level has settled
  task automatic wt(input logic l, input int n);
    @(negedge clock);
    for (int i = 0; i < n && irq_n !== l; i++) @(negedge clock);
    `CHK(irq_n, l)
    if (irq_n !== l) finish_test();
    @(posedge clock);
  endtask : wt
  initial begin
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rd(8'h01, 8'h00);
    rd(8'h05, 8'h00);
    wr(8'h0E, 8'hFF);
    rd(8'h0E, 8'h7B);
    wr(8'h01, 8'h02);
    pulse(3'h2);
    wt(1'b0, 4);
    wr(8'h01, 8'h0A);
    rd(8'h01, 8'h0A);
    wr(8'h01, 8'h02);
    wt(1'b1, 2);
    wr(8'h01, 8'h90);
    pulse(3'h4);
    wt(1'b0, 4);
    wt(1'b1, 64);
    rd(8'h01, 8'hB0);
    pulse(3'h4);
    wr(8'h01, 8'h90);
    wt(1'b1, 2);
    wr(8'h01, 8'h80);
    pulse(3'h4);
    // longer than any minute pulse, so only the level keeps it low
    repeat (40) @(posedge clock);
    wt(1'b0, 0);
    wr(8'h01, 8'h20);
    wt(1'b1, 2);
    wr(8'h01, 8'h11);
    wr(8'h0E, 8'h79);
    wr(8'h0F, 8'h03);
    wt(1'b0, 200);
    wt(1'b1, 40);
    repeat (8) @(posedge clock);
    rd(8'h0F, 8'h02);
    rd(8'h0F, 8'h02);
    rd(8'h01, 8'h15);
    wr(8'h01, 8'h05);
    wt(1'b0, 2);
    wr(8'h01, 8'h04);
    wt(1'b1, 2);
    wr(8'h01, 8'h11);
    wt(1'b0, 200);
    wr(8'h01, 8'h11);
    wt(1'b1, 2);
    wr(8'h0F, 8'h00);
    wr(8'h01, 8'h00);
    repeat (300) @(posedge clock);
    rd(8'h01, 8'h00);
    ca <= 1'b1;
    for (int i = 0; i < 16 && tc[3:0] !== 4'h0; i++) @(posedge clock);
    pulse(3'h1);
    wt(1'b0, 2);
    wr(8'h00, 8'h20);
    wt(1'b1, 2);
    finish_test();
  end
endmodule : rtcf_irq_tb
